// >>> design/cbs_consts.svh
// Constants of the bus cycle sequencer: offsets, masks, reset values and timing counts.
// Assumes it is included by bare name from the sequencer's design files.
`ifndef CBS_CONSTS_SVH
`define CBS_CONSTS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define CBS_CLK_PERIOD_NS 10
// One bus state lasts two periods of the double-rate clock.
`define CBS_CLKS_PER_STATE 2

// ****************************************************************
// Address, data and lane layout
// ****************************************************************
`define CBS_ADDR_LSB 2
`define CBS_HALF_W 16
`define CBS_LOW_LANES 4'h3
`define CBS_HIGH_LANES 4'hc
`define CBS_NO_LANES_N 4'hf

// ****************************************************************
// Reset values
// ****************************************************************
`define CBS_RST_STROBE_N 1'b1
`define CBS_RST_OE_N 1'b1
`define CBS_RST_HOLD_ACK 1'b0

`endif

// >>> design/cbs_pkg.sv
// Types shared by the bus cycle sequencer files.
// Assumes the constants header sits beside this package.
`include "cbs_consts.svh"

package cbs_pkg;

    // Bus states; the last two exist only on the way into pipelined timing.
    typedef enum logic [2:0] {
        bus_idle_state,
        addr_state,
        data_state,
        hold_ack_state,
        pipe_wait_no_addr_state,
        pipe_wait_addr_state
    } cbs_state_t;

    // Cycle definition bits, carried unchanged to the pins.
    typedef logic [2:0] cbs_def_t;

    // Whole state of the sequencer, registered as one word.
    typedef struct packed {
        cbs_state_t st;
        logic [29:0] addr;
        logic [3:0] be_n;
        cbs_def_t def;
        logic wr;
        logic [31:0] wdata;
        logic nwr;
        logic [31:0] nwdata;
        logic second;
        logic na_seen;
        logic [31:0] rdata;
        logic ads_n;
        logic oe_n;
        logic [31:0] dout;
        logic hlda;
        logic taken;
        logic done;
    } cbs_seq_t;

endpackage : cbs_pkg

// >>> design/cbs_tick_if.sv
// Carrier of the phase timing from the phase generator to the sequencer.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps

interface cbs_tick_if;
    logic phase_two;
    logic state_end;

    modport gen (output phase_two, output state_end);
    modport use_side (input phase_two, input state_end);
endinterface : cbs_tick_if

// >>> design/cbs_phase_gen.sv
// Phase generator: splits each bus state into phase one and phase two.
// Assumes clk_sys is the double-rate clock and nrst is asynchronous, active low.
`timescale 1ns/1ps
`include "cbs_consts.svh"

module cbs_phase_gen #(
    parameter int CLKS_PER_STATE = `CBS_CLKS_PER_STATE
) (
    input wire logic clk_sys,
    input wire logic nrst,
    cbs_tick_if.gen tick
);
    localparam int CW = (CLKS_PER_STATE > 1) ? $clog2(CLKS_PER_STATE) : 1;
    localparam logic [CW-1:0] LAST = CW'(CLKS_PER_STATE - 1);
    localparam logic [CW-1:0] HALF = CW'(CLKS_PER_STATE / 2);

    typedef struct packed {
        logic [CW-1:0] cnt;
    } cbs_ph_t;

    cbs_ph_t s;
    cbs_ph_t next_s;

    // The counter wraps at the end of each bus state.
    always_comb begin
        next_s = s;
        next_s.cnt = (s.cnt == LAST) ? '0 : CW'(s.cnt + 1'b1);
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Phase two is the second half of the state; its last clock closes the state.
    assign tick.phase_two = (s.cnt >= HALF);
    assign tick.state_end = (s.cnt == LAST);
endmodule : cbs_phase_gen

// >>> design/cbs_sequencer.sv
// Bus cycle sequencer for the processor's local bus, non-pipelined and pipelined address timing.
// Assumes the core presents one request at a time that stays inside one aligned dword,
// and that external logic drives ready_n, next_addr_request_n and narrow_bus_select_n
// synchronously to clk_sys.
// Assumes hold_req is a level that stays up until hold_ack answers it, and that
// narrow_bus_select_n stays asserted through the second half of a split transfer.
`timescale 1ns/1ps
`include "cbs_consts.svh"

module cbs_sequencer (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire cbs_pkg::cbs_def_t req_def,
    input wire logic [31:0] req_addr,
    input wire logic [1:0] req_size,
    input wire logic [31:0] req_wdata,
    output logic req_taken,
    output logic done,
    output logic [31:0] rd_data,
    input wire logic ready_n,
    input wire logic next_addr_request_n,
    input wire logic narrow_bus_select_n,
    input wire logic hold_req,
    input wire logic [31:0] data_in,
    output logic [31:2] addr,
    output logic [3:0] lane_enable_n,
    output cbs_pkg::cbs_def_t cyc_def,
    output logic addr_valid_strobe_n,
    output logic [31:0] data_out,
    output logic data_oe_n,
    output logic hold_ack
);
    import cbs_pkg::*;

    // ****************************************************************
    // Phase timing
    // ****************************************************************

    // The two phase flags travel together; every decision below waits on one of them.
    // Only the phase generator writes them.
    cbs_tick_if tick ();

    // Each bus state is two clocks: phase one, then phase two.
    cbs_phase_gen #(
        .CLKS_PER_STATE(`CBS_CLKS_PER_STATE)
    ) u_phase (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .tick(tick)
    );

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Lanes touched by an operand of req_size+1 bytes at the given byte offset.
    // Bytes past lane three are dropped; the core must not cross a dword.
    // A request that did would only lose its upper lanes on the pins; nothing hangs on it,
    // so no hardware was spent on checking it.
    function automatic logic [3:0] cbs_lanes(input logic [1:0] ofs, input logic [1:0] size);
        logic [6:0] ones;
        logic [6:0] shifted;
        ones = 7'h0f >> (2'd3 - size);
        shifted = ones << ofs;
        return shifted[3:0];
    endfunction : cbs_lanes

    // Present and next state words; only the register below writes s.
    cbs_seq_t s;
    cbs_seq_t next_s;

    // Decodes shared by the next-state logic.
    logic ack;
    logic drive;
    logic split;
    logic uses_low; // Operand has a lane in the low data half.
    logic uses_high; // Operand has a lane in the high data half.
    logic [3:0] req_lanes_n;

    // Acknowledge is only looked at on the last clock of a state.
    assign ack = tick.state_end && !ready_n;
    assign req_lanes_n = ~cbs_lanes(req_addr[1:0], req_size);

    // Write data is driven only while a write cycle owns the bus.
    assign drive = s.wr && (s.st != bus_idle_state) && (s.st != hold_ack_state);

    // An operand wholly inside one half moves in a single cycle even on a narrow bus,
    // latched or driven whole.
    assign uses_low = ((~s.be_n & `CBS_LOW_LANES) != 4'h0);
    assign uses_high = ((~s.be_n & `CBS_HIGH_LANES) != 4'h0);

    // An extra 16-bit cycle is needed when the sample taken with the acknowledge says
    // narrow and the operand uses both halves; narrow beats next-address here.
    assign split = (s.st == data_state) && !narrow_bus_select_n && !s.second
        && uses_low && uses_high;

    // ****************************************************************
    // Next state
    // ****************************************************************

    // Everything moves on the last clock of a bus state; the first clock of a state
    // only samples next-address and refreshes the data pins. A plain cycle runs:
    //   idle, state end with a request: strobe low, address, lanes, definition out;
    //   address state, first clock: old write data held, new data driven at its end;
    //   address state end: strobe back high, data state entered;
    //   data state, first clock: next-address sampled;
    //   data state end with acknowledge: read data latched, done pulse, next state.
    // Without acknowledge or a sampled next-address the data state repeats and the address pins stay put.
    // Pipelined waits are entered from a data state; the address wait also from the wait without an address.
    // Trade-off: a request that arrives in a first clock waits one clock for the
    // state end, but every output stays a plain register field and all decode
    // sits in this process and the decode assigns above it.
    always_comb begin
        next_s = s;
        next_s.taken = 1'b0;
        next_s.done = 1'b0;

        if (!tick.phase_two) begin
            // Next-address is sampled at the end of phase one of a data state; it only
            // counts while narrow-bus select is negated in the same window.
            if (s.st == data_state && !next_addr_request_n && narrow_bus_select_n) begin
                next_s.na_seen = 1'b1;
            end
            // Data pins change only at the end of phase one, so old write data stays
            // through phase one of the next state and new data starts in phase two.
            next_s.oe_n = !drive;
            if (drive) begin
                // Second 16-bit write carries the upper half on the low half.
                next_s.dout = s.second ? {s.wdata[31:16], s.wdata[31:16]} : s.wdata;
            end
        end else if (tick.state_end) begin
            // The strobe covers exactly one state.
            next_s.ads_n = 1'b1;
            unique case (s.st)
                addr_state: begin
                    // Address state always leads to a data state.
                    next_s.st = data_state;
                    next_s.na_seen = 1'b0;
                end

                data_state, pipe_wait_no_addr_state, pipe_wait_addr_state: begin
                    if (ack) begin
                        // Read data are latched on the accepted acknowledge.
                        if (!s.wr) begin
                            if (s.second) begin
                                next_s.rdata[31:16] = data_in[15:0];
                            end else begin
                                next_s.rdata = data_in;
                            end
                        end
                        if (split) begin
                            // Same address, lanes zero and one negated, same path.
                            next_s.st = addr_state;
                            next_s.be_n = s.be_n | `CBS_LOW_LANES;
                            next_s.second = 1'b1;
                            next_s.ads_n = 1'b0;
                        end else begin
                            next_s.done = 1'b1;
                            next_s.second = 1'b0;
                            if (s.st == pipe_wait_addr_state) begin
                                // Next address is already on the pins; its first state
                                // opens without a fresh strobe.
                                next_s.st = addr_state;
                                next_s.wr = s.nwr;
                                next_s.wdata = s.nwdata;
                            end else if (hold_req) begin
                                // Hold wins over a pending request.
                                next_s.st = hold_ack_state;
                                next_s.hlda = 1'b1;
                            end else if (req_valid) begin
                                next_s.st = addr_state;
                                next_s.addr = req_addr[31:`CBS_ADDR_LSB];
                                next_s.be_n = req_lanes_n;
                                next_s.def = req_def;
                                next_s.wr = req_write;
                                next_s.wdata = req_wdata;
                                next_s.ads_n = 1'b0;
                                next_s.taken = 1'b1;
                            end else begin
                                next_s.st = bus_idle_state;
                            end
                        end
                    end else if (s.st == data_state && !s.na_seen) begin
                        // Wait state: everything on the address pins stays put.
                        next_s.st = data_state;
                    end else if (s.st != pipe_wait_addr_state && req_valid) begin
                        // Pipelined wait with the next address presented early.
                        next_s.st = pipe_wait_addr_state;
                        next_s.addr = req_addr[31:`CBS_ADDR_LSB];
                        next_s.be_n = req_lanes_n;
                        next_s.def = req_def;
                        next_s.nwr = req_write;
                        next_s.nwdata = req_wdata;
                        next_s.ads_n = 1'b0;
                        next_s.taken = 1'b1;
                    end else if (s.st == data_state) begin
                        // Pipelined wait with nothing to present yet.
                        next_s.st = pipe_wait_no_addr_state;
                    end
                end

                bus_idle_state, hold_ack_state: begin
                    // Hold is granted only at a state end between cycles.
                    if (hold_req) begin
                        next_s.st = hold_ack_state;
                        next_s.hlda = 1'b1;
                    end else if (req_valid) begin
                        // A cycle out of idle or hold is never pipelined.
                        next_s.st = addr_state;
                        next_s.hlda = 1'b0;
                        next_s.addr = req_addr[31:`CBS_ADDR_LSB];
                        next_s.be_n = req_lanes_n;
                        next_s.def = req_def;
                        next_s.wr = req_write;
                        next_s.wdata = req_wdata;
                        next_s.second = 1'b0;
                        next_s.ads_n = 1'b0;
                        next_s.taken = 1'b1;
                    end else begin
                        next_s.st = bus_idle_state;
                        next_s.hlda = 1'b0;
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************

    // One register word holds every piece of state; reset parks the bus idle and released.
    // Only constants appear in the reset branch, so the release edge cannot load
    // a half-settled pin into the state word; the phase counter restarts with it,
    // so the first clock after release is always a first clock of a state.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
            s.st <= bus_idle_state;
            s.be_n <= `CBS_NO_LANES_N;
            s.ads_n <= `CBS_RST_STROBE_N;
            s.oe_n <= `CBS_RST_OE_N;
            s.hlda <= `CBS_RST_HOLD_ACK;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    // Every output is a field of the state register, so none glitches.
    // Nothing is combined after the register, which keeps strobe and hold clean.

    // Core side: the two pulses and the read data word.
    assign req_taken = s.taken;
    assign done = s.done;
    assign rd_data = s.rdata;

    // Address side: held from one strobe to the next.
    assign addr = s.addr;
    assign lane_enable_n = s.be_n;
    assign cyc_def = s.def;
    assign addr_valid_strobe_n = s.ads_n;

    // Data side: the enable is low while write data are on the pins.
    assign data_out = s.dout;
    assign data_oe_n = s.oe_n;

    // Hold side: high for as long as the bus is handed over.
    assign hold_ack = s.hlda;
endmodule : cbs_sequencer

// >>> tb/cbs_bus_model.sv
// Far-side model: acknowledge, bus size, next-address and read data for the sequencer.
// Assumes the bench sets wt, nb, na_at and rv before each request and holds them until done.
`timescale 1ns/1ps

module cbs_bus_model (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic addr_valid_strobe_n,
    input wire logic [31:0] rv,
    input wire logic nb,
    input int wt,
    input int na_at,
    output logic ready_n,
    output logic next_addr_request_n,
    output logic narrow_bus_select_n,
    output logic [31:0] data_in
);
    int cnt;
    int n;
    logic strobe_q;

    // Count clocks from the first strobe clock; every reply is placed on that count.
    // Released data lines toggle so a stale value never passes for fresh read data.
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt <= 0;
            strobe_q <= 1'b1;
            ready_n <= 1'b1;
            next_addr_request_n <= 1'b1;
            narrow_bus_select_n <= 1'b1;
            data_in <= 32'h0;
        end else begin
            n = (!addr_valid_strobe_n && strobe_q) ? 1 : cnt + 1;
            cnt <= n;
            strobe_q <= addr_valid_strobe_n;
            ready_n <= !(n == 3 + 2 * wt);
            next_addr_request_n <= !(n == na_at);
            narrow_bus_select_n <= !(nb && n >= 2 + 2 * wt && n <= 3 + 2 * wt);
            data_in <= (n == 3 + 2 * wt) ? rv : ~data_in;
        end
    end
endmodule : cbs_bus_model

// >>> tb/cbs_sequencer_chk.sv
// Checker of port timing for the bus cycle sequencer.
// Assumes it is bound to cbs_sequencer and that acknowledge is low only in sampled clocks.
`timescale 1ns/1ps

module cbs_sequencer_chk (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic req_write,
    input wire logic req_taken,
    input wire logic done,
    input wire logic [31:0] rd_data,
    input wire logic ready_n,
    input wire logic narrow_bus_select_n,
    input wire logic hold_req,
    input wire logic [31:0] data_in,
    input wire logic [31:2] addr,
    input wire logic [3:0] lane_enable_n,
    input wire cbs_pkg::cbs_def_t cyc_def,
    input wire logic addr_valid_strobe_n,
    input wire logic [31:0] data_out,
    input wire logic data_oe_n,
    input wire logic hold_ack
);
    import cbs_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    logic split_pend;
    logic [3:0] lanes_q;
    logic both_half;

    // A narrow acknowledge of a cycle using both halves owes a second cycle.
    assign both_half = (lane_enable_n[1:0] != 2'b11) && (lane_enable_n[3:2] != 2'b11);
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            split_pend <= 1'b0;
            lanes_q <= 4'hf;
        end else if (!ready_n) begin
            split_pend <= !narrow_bus_select_n && both_half;
            lanes_q <= lane_enable_n;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    strobe_len_a: assert property ($fell(addr_valid_strobe_n) |=> !addr_valid_strobe_n
        ##1 addr_valid_strobe_n)
        else $error("strobe not two clocks long");
    taken_strobe_a: assert property (req_taken |-> $fell(addr_valid_strobe_n))
        else $error("request taken without address state");
    min_cycle_a: assert property (req_taken |=> !done [*3])
        else $error("cycle shorter than two states");
    ack_done_a: assert property (done |-> !$past(ready_n) && $past(addr_valid_strobe_n))
        else $error("done without acknowledge in data state");
    addr_stable_a: assert property (addr_valid_strobe_n && $past(addr_valid_strobe_n)
        |-> $stable(addr) && $stable(cyc_def))
        else $error("address moved without strobe");
    write_drive_a: assert property (req_taken && req_write |=> !data_oe_n [*3])
        else $error("write data not driven");
    write_hold_a: assert property (done && !$past(data_oe_n) |-> !data_oe_n && $stable(data_out))
        else $error("write data not held");
    read_float_a: assert property (req_taken && !req_write |=> data_oe_n [*3])
        else $error("data driven during read");
    read_latch_a: assert property (done && $past(data_oe_n) && $past(narrow_bus_select_n)
        |-> rd_data == $past(data_in))
        else $error("read data not latched");
    split_lanes_a: assert property ($fell(addr_valid_strobe_n) && split_pend
        |-> lane_enable_n == (lanes_q | 4'h3))
        else $error("second half lanes wrong");
    split_nodone_a: assert property (!ready_n && !narrow_bus_select_n && both_half
        |=> !done && !addr_valid_strobe_n)
        else $error("split cycle ended early");
    hold_entry_a: assert property ($rose(hold_ack) |-> $past(hold_req) && addr_valid_strobe_n)
        else $error("hold without request");

    split_c: cover property (!ready_n && !narrow_bus_select_n && both_half);
    wait_c: cover property ($fell(addr_valid_strobe_n) ##3 ready_n ##1 ready_n);
    hold_c: cover property ($rose(hold_ack));
endmodule : cbs_sequencer_chk

bind cbs_sequencer cbs_sequencer_chk u_chk (.clk_sys, .nrst, .req_write, .req_taken, .done, .rd_data, .ready_n,
    .narrow_bus_select_n, .hold_req, .data_in, .addr, .lane_enable_n, .cyc_def, .addr_valid_strobe_n, .data_out,
    .data_oe_n, .hold_ack);

// >>> tb/testbench.sv
// Self-checking bench for the bus cycle sequencer with a far-side model.
// Assumes one request at a time; each op holds the model settings until its done.
`timescale 1ns/1ps

module testbench;
    import cbs_pkg::*;
    typedef struct {logic w; logic [31:0] d; int lat;} cbs_exp_t;
    logic clk_sys, nrst, req_valid, req_write, req_taken, done, hold_req, nb;
    logic ready_n, next_addr_request_n, narrow_bus_select_n, addr_valid_strobe_n, data_oe_n, hold_ack;
    logic [1:0] req_size;
    logic [3:0] lane_enable_n;
    logic [31:2] addr;
    logic [31:0] req_addr, req_wdata, rd_data, data_in, data_out, rv, a;
    cbs_def_t req_def, cyc_def;
    int wt, na_at, errors, compares, cyc, seed;
    cbs_exp_t exq[$];
    cbs_exp_t e;
    int tq[$];

    cbs_sequencer dut (.clk_sys, .nrst, .req_valid, .req_write, .req_def, .req_addr, .req_size, .req_wdata,
        .req_taken, .done, .rd_data, .ready_n, .next_addr_request_n, .narrow_bus_select_n, .hold_req, .data_in,
        .addr, .lane_enable_n, .cyc_def, .addr_valid_strobe_n, .data_out, .data_oe_n, .hold_ack);
    cbs_bus_model bm (.clk_sys, .nrst, .addr_valid_strobe_n, .rv, .nb, .wt, .na_at, .ready_n,
        .next_addr_request_n, .narrow_bus_select_n, .data_in);

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, want);
        end
    endtask : chk

    // One transfer; the expectation is noted before the request is raised.
    task automatic op(input logic w, input logic [31:0] ad, input logic [1:0] sz, input int w8,
        input logic n16, input int na);
        logic [31:0] wd;
        logic [31:0] r;
        logic [3:0] ln;
        logic sp;
        wd = $random(seed);
        r = $random(seed);
        ln = (4'hf >> (2'd3 - sz)) << ad[1:0];
        sp = n16 && (ln[1:0] != 2'b00) && (ln[3:2] != 2'b00);
        exq.push_back('{w, sp ? (w ? {2{wd[31:16]}} : {2{r[15:0]}}) : (w ? wd : r), (sp ? 8 : 4) + (sp ? 4 : 2) * w8});
        @(posedge clk_sys);
        rv <= r;
        nb <= n16;
        wt <= w8;
        na_at <= na;
        req_valid <= 1'b1;
        req_write <= w;
        req_addr <= ad;
        req_size <= sz;
        req_wdata <= wd;
        req_def <= cbs_def_t'(r[2:0]);
        do @(negedge clk_sys); while (req_taken !== 1'b1);
        chk({28'h0, lane_enable_n}, {28'h0, ~ln});
        chk({addr, 2'b00}, {ad[31:2], 2'b00});
        chk(32'(cyc_def), 32'(r[2:0]));
        @(posedge clk_sys);
        req_valid <= 1'b0;
        do @(negedge clk_sys); while (done !== 1'b1);
    endtask : op

    task automatic report_and_stop;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    // Result monitor: cycle length, write data in its hold phase, read data.
    always @(negedge clk_sys) begin
        cyc++;
        if (req_taken === 1'b1) begin
            tq.push_back(cyc);
        end
        if (done === 1'b1) begin
            e = exq.pop_front();
            chk(32'(cyc - tq.pop_front()), 32'(e.lat));
            if (e.w) begin
                chk(data_out, e.d);
                chk(32'(data_oe_n), 32'h0);
            end else begin
                chk(rd_data, e.d);
            end
        end
    end

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Watchdog well beyond the expected run of a few hundred clocks.
    initial begin
        repeat (5000) @(posedge clk_sys);
        errors++;
        report_and_stop;
    end

    initial begin
        seed = 32'h2618;
        {nrst, req_valid, req_write, hold_req, nb, req_size, req_addr, req_wdata, rv, req_def} = '0;
        {wt, na_at, errors, compares, cyc} = '0;
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        // Random directions, sizes and widths; wait counts cycle through 0, 1, 2.
        for (int i = 0; i < 16; i++) begin
            a = $random(seed);
            if ({1'b0, a[1:0]} + {1'b0, a[5:4]} > 3'd3) begin
                a[1:0] = 2'b00;
            end
            op(a[6], a, a[5:4], i % 3, a[7], 0);
        end
        $display("test random mix done");
        // Narrow select and next-address together: split, no pipelining.
        op(1'b0, 32'h0000_0010, 2'd3, 1, 1'b1, 4);
        op(1'b1, 32'h0000_0024, 2'd3, 0, 1'b1, 2);
        $display("test narrow priority done");
        // Next-address in a non-final data state with nothing pending: pipelined wait, same length.
        op(1'b0, 32'h0000_0030, 2'd3, 1, 1'b0, 2);
        op(1'b1, 32'h0000_0034, 2'd3, 2, 1'b0, 2);
        $display("test early next-address done");
        // A request raised during hold waits until hold is dropped.
        @(posedge clk_sys);
        hold_req <= 1'b1;
        fork
            begin
                repeat (10) @(negedge clk_sys);
                chk(32'(hold_ack), 32'h1);
                chk(32'(addr_valid_strobe_n), 32'h1);
                @(posedge clk_sys);
                hold_req <= 1'b0;
            end
            op(1'b0, 32'h0000_0040, 2'd3, 0, 1'b0, 0);
        join
        $display("test hold done");
        repeat (4) @(negedge clk_sys);
        report_and_stop;
    end
endmodule : testbench
